/* File: core/secl_pkg.sv */
// constants and types for the serial eeprom configuration loader
package secl_pkg;
  // ****************************************************
  // register offsets
  // ****************************************************
  localparam logic [7:0] SECL_CTRL_OFS = 8'h00;
  localparam logic [7:0] SECL_CFG_OFS = 8'h04;
  localparam logic [7:0] SECL_BASE_OFS = 8'h08;
  localparam logic [7:0] SECL_STA0_OFS = 8'h0C;
  localparam logic [7:0] SECL_STA1_OFS = 8'h10;
  localparam logic [7:0] SECL_STA2_OFS = 8'h14;
  localparam logic [7:0] SECL_GP_OFS = 8'h18;
  localparam logic [7:0] SECL_PTR_OFS = 8'h1C;
  localparam logic [7:0] SECL_STAT_OFS = 8'h20;
  // ****************************************************
  // control word fields
  // ****************************************************
  localparam int SECL_SEL_BIT = 0;
  localparam int SECL_LOAD_BIT = 1;
  localparam int SECL_SAVE_BIT = 2;
  localparam logic [15:0] SECL_CTRL_KEEP = 16'hFFF9;
  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [15:0] SECL_CTRL_RST = 16'h0000;
  localparam logic [15:0] SECL_CFG_RST = 16'h0000;
  localparam logic [15:0] SECL_BASE_RST = 16'h0000;
  localparam logic [15:0] SECL_STA_RST = 16'h0000;
  localparam logic [15:0] SECL_GP_RST = 16'h0000;
  localparam logic [15:0] SECL_PTR_RST = 16'h0000;
  // ****************************************************
  // eeprom map and command codes
  // ****************************************************
  localparam logic [2:0] SECL_STRAP_FIXED = 3'h7;
  localparam logic [5:0] SECL_STATION_WORD = 6'h20;
  localparam logic [5:0] SECL_EWEN_ADDR = 6'h30;
  localparam logic [2:0] SECL_STEP_BASE = 3'h1;
  localparam logic [2:0] SECL_STEP_STA = 3'h2;
  localparam logic [2:0] SECL_STEP_LAST = 3'h4;
  localparam logic [4:0] SECL_HDR_BITS = 5'h09;
  localparam logic [4:0] SECL_FRAME_BITS = 5'h19;
  typedef enum logic [1:0] {
    SECL_CMD_EN = 2'b00,
    SECL_CMD_WR = 2'b01,
    SECL_CMD_RD = 2'b10
  } secl_cmd_t;
  // ****************************************************
  // timing
  // ****************************************************
  localparam int SECL_CLK_MHZ = 100;
  localparam int SECL_SK_HALF_NS = 500;
  localparam int SECL_SK_HALF_CYC = (SECL_SK_HALF_NS * SECL_CLK_MHZ + 999) / 1000;
endpackage

/* File: core/secl_uwire.sv */
// three-wire serial eeprom word shifter
`timescale 1ns/10ps
`default_nettype none
module secl_uwire #(
  parameter int SK_HALF = secl_pkg::SECL_SK_HALF_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire secl_pkg::secl_cmd_t cmd,
  input wire logic [5:0] addr,
  input wire logic [15:0] wdata,
  output logic done,
  output logic [15:0] rdata,
  output logic rom_cs,
  output logic rom_sk,
  output logic rom_di,
  input wire logic rom_do
);
  import secl_pkg::*;
  typedef enum logic [4:0] {
    SECL_U_IDLE = 5'b00001,
    SECL_U_LOW = 5'b00010,
    SECL_U_HIGH = 5'b00100,
    SECL_U_GAP = 5'b01000,
    SECL_U_BUSY = 5'b10000
  } secl_ust_t;
  secl_ust_t st_q;
  secl_cmd_t cmd_q;
  logic [24:0] sh_q;
  logic [4:0] bit_q;
  logic [7:0] tm_q;
  logic [15:0] rd_q;
  wire tm_end = tm_q == 8'(SK_HALF - 1);
  wire [4:0] nbits = cmd_q == SECL_CMD_EN ? SECL_HDR_BITS : SECL_FRAME_BITS;
  wire last_bit = bit_q == nbits - 5'd1;
  wire rd_bit = cmd_q == SECL_CMD_RD && bit_q >= SECL_HDR_BITS;
  wire [5:0] cmd_addr = cmd == SECL_CMD_EN ? SECL_EWEN_ADDR : addr;
  // ****************************************************
  // frame sequencer
  // ****************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= SECL_U_IDLE;
      cmd_q <= SECL_CMD_EN;
      sh_q <= '0;
      bit_q <= '0;
      tm_q <= '0;
      rd_q <= '0;
    end else begin
      tm_q <= (st_q == SECL_U_IDLE || tm_end) ? 8'h00 : tm_q + 8'h01;
      unique case (st_q)
        SECL_U_IDLE: if (start) begin
          cmd_q <= cmd;
          sh_q <= {1'b1, cmd, cmd_addr, wdata};
          bit_q <= '0;
          st_q <= SECL_U_LOW;
        end
        SECL_U_LOW: if (tm_end) st_q <= SECL_U_HIGH;
        SECL_U_HIGH: if (tm_end) begin
          if (rd_bit) rd_q <= {rd_q[14:0], rom_do};
          sh_q <= {sh_q[23:0], 1'b0};
          bit_q <= bit_q + 5'd1;
          st_q <= last_bit ? SECL_U_GAP : SECL_U_LOW;
        end
        SECL_U_GAP: if (tm_end) begin
          st_q <= cmd_q == SECL_CMD_WR ? SECL_U_BUSY : SECL_U_IDLE;
        end
        SECL_U_BUSY: if (rom_do) st_q <= SECL_U_IDLE;
      endcase
    end
  end
  assign done = (st_q == SECL_U_GAP && tm_end && cmd_q != SECL_CMD_WR)
    || (st_q == SECL_U_BUSY && rom_do);
  assign rdata = rd_q;
  assign rom_cs = st_q inside {SECL_U_LOW, SECL_U_HIGH, SECL_U_BUSY};
  assign rom_sk = st_q == SECL_U_HIGH;
  assign rom_di = rom_cs && st_q != SECL_U_BUSY && sh_q[24];
  // ****************************************************
  // checks
  // ****************************************************
  a_frame_select: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == SECL_U_IDLE && start |=> rom_cs && rom_di && !rom_sk)
    else $error("frame did not open with start bit");
endmodule
`default_nettype wire

/* File: core/secl_loader.sv */
// eeprom configuration loader with ahb-lite register slave
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - strap value 7 loads only station address words, keeping setup words
// - strap 7 after reset leaves setup registers at reset defaults
// - target select 0 means setup transfers, 1 means single word transfers
// - setup word read from strap times four, base word from next
// - station address loaded from words 20h to 22h whatever the straps
// - save writes setup and base words to the strap-selected words
// - low three control bits never go to or come from the eeprom
// - single word load reads word at pointer low six bits into gp
// - single word save writes gp to word at pointer low six bits
// - both request bits read high while a transfer runs
// - other register accesses wait until transfer ends, reset load too
// - without eeprom no access; registers keep reset defaults
// - eeprom is 64 words of 16 bits with six-bit word address
// - every transfer moves a whole word at a word address
// - every hardware reset with eeprom present runs a load, station words only under strap 7
module secl_loader #(
  parameter int SK_HALF = secl_pkg::SECL_SK_HALF_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [2:0] board_strap_pins,
  input wire logic rom_present_pin,
  output logic rom_cs,
  output logic rom_sk,
  output logic rom_di,
  input wire logic rom_do
);
  import secl_pkg::*;
  typedef enum logic [2:0] {
    SECL_Q_IDLE = 3'b001,
    SECL_Q_ISSUE = 3'b010,
    SECL_Q_WAIT = 3'b100
  } secl_seq_t;
  // ****************************************************
  // state
  // ****************************************************
  logic ap_q;
  logic ap_wr_q;
  logic [7:0] ap_addr_q;
  logic [15:0] control_word_q;
  logic [15:0] cfg_q;
  logic [15:0] base_q;
  logic [15:0] sta_q [3];
  logic [15:0] gp_q;
  logic [15:0] ptr_q;
  secl_seq_t seq_q;
  logic boot_q;
  logic load_q;
  logic gp_mode_q;
  logic ewen_q;
  logic [2:0] step_q;
  logic [2:0] last_q;
  secl_cmd_t prev_cmd_q;
  logic rom_done;
  logic [15:0] rom_rdata;
  // ****************************************************
  // bus decode
  // ****************************************************
  wire boot_go = boot_q && rom_present_pin;
  wire busy = seq_q != SECL_Q_IDLE || boot_go;
  wire ap_take = hsel && htrans[1] && hready;
  wire sel_ctrl = ap_addr_q == SECL_CTRL_OFS;
  wire stall = ap_q && busy && !sel_ctrl;
  wire wr_en = ap_q && ap_wr_q && !busy;
  wire wr_ctrl = wr_en && sel_ctrl;
  wire wr_cfg = wr_en && ap_addr_q == SECL_CFG_OFS;
  wire wr_base = wr_en && ap_addr_q == SECL_BASE_OFS;
  wire wr_gp = wr_en && ap_addr_q == SECL_GP_OFS;
  wire wr_ptr = wr_en && ap_addr_q == SECL_PTR_OFS;
  wire [2:0] wr_sta;
  wire req_load = wr_ctrl && hwdata[SECL_LOAD_BIT] && rom_present_pin;
  wire req_save = wr_ctrl && hwdata[SECL_SAVE_BIT]
    && !hwdata[SECL_LOAD_BIT] && rom_present_pin;
  wire go_load = boot_go || req_load;
  wire start_now = seq_q == SECL_Q_IDLE && (go_load || req_save);
  wire go_gp = !boot_go && hwdata[SECL_SEL_BIT];
  wire skip_setup = board_strap_pins == SECL_STRAP_FIXED;
  genvar gi;
  for (gi = 0; gi < 3; gi++) begin : g_sta_dec
    assign wr_sta[gi] = wr_en && ap_addr_q == SECL_STA0_OFS + 8'(4 * gi);
  end
  // ****************************************************
  // eeprom word selection
  // ****************************************************
  wire [2:0] sta_idx = step_q - SECL_STEP_STA;
  wire [5:0] setup_addr = {1'b0, board_strap_pins, 1'b0, step_q[0]};
  wire [5:0] sta_addr = SECL_STATION_WORD + {3'b000, sta_idx};
  wire [5:0] word_addr = gp_mode_q ? ptr_q[5:0]
    : step_q < SECL_STEP_STA ? setup_addr : sta_addr;
  wire [15:0] word_out = gp_mode_q ? gp_q
    : step_q[0] ? base_q : cfg_q;
  wire secl_cmd_t word_cmd = ewen_q ? SECL_CMD_EN
    : load_q ? SECL_CMD_RD : SECL_CMD_WR;
  wire rom_start = seq_q == SECL_Q_ISSUE;
  wire word_done = seq_q == SECL_Q_WAIT && rom_done && !ewen_q;
  wire ld_we = word_done && load_q;
  wire ld_cfg = ld_we && !gp_mode_q && step_q == 3'h0;
  wire ld_base = ld_we && !gp_mode_q && step_q == SECL_STEP_BASE;
  wire ld_gp = ld_we && gp_mode_q;
  wire ld_sta = ld_we && !gp_mode_q && step_q >= SECL_STEP_STA;
  // ****************************************************
  // bus phase tracking
  // ****************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= 1'b0;
      ap_wr_q <= 1'b0;
      ap_addr_q <= '0;
    end else if (hready) begin
      ap_q <= ap_take;
      ap_wr_q <= hwrite;
      ap_addr_q <= haddr[7:0];
    end
  end
  // ****************************************************
  // transfer sequencer
  // ****************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_q <= SECL_Q_IDLE;
      boot_q <= 1'b1;
      load_q <= 1'b0;
      gp_mode_q <= 1'b0;
      ewen_q <= 1'b0;
      step_q <= '0;
      last_q <= '0;
    end else begin
      unique case (seq_q)
        SECL_Q_IDLE: begin
          boot_q <= 1'b0;
          if (start_now) begin
            load_q <= go_load;
            gp_mode_q <= go_gp;
            ewen_q <= !go_load;
            step_q <= (go_load && !go_gp && skip_setup)
              ? SECL_STEP_STA : 3'h0;
            last_q <= go_gp ? 3'h0
              : go_load ? SECL_STEP_LAST : SECL_STEP_BASE;
            seq_q <= SECL_Q_ISSUE;
          end
        end
        SECL_Q_ISSUE: seq_q <= SECL_Q_WAIT;
        SECL_Q_WAIT: if (rom_done) begin
          if (ewen_q) begin
            ewen_q <= 1'b0;
            seq_q <= SECL_Q_ISSUE;
          end else if (step_q == last_q) begin
            seq_q <= SECL_Q_IDLE;
          end else begin
            step_q <= step_q + 3'h1;
            ewen_q <= !load_q;
            seq_q <= SECL_Q_ISSUE;
          end
        end
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) prev_cmd_q <= SECL_CMD_RD;
    else if (rom_start) prev_cmd_q <= word_cmd;
  end
  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_word_q <= SECL_CTRL_RST;
      cfg_q <= SECL_CFG_RST;
      base_q <= SECL_BASE_RST;
      gp_q <= SECL_GP_RST;
      ptr_q <= SECL_PTR_RST;
    end else begin
      if (wr_ctrl) begin
        control_word_q <= hwdata[15:0] & SECL_CTRL_KEEP;
      end
      if (wr_cfg || ld_cfg) cfg_q <= wr_cfg ? hwdata[15:0] : rom_rdata;
      if (wr_base || ld_base) begin
        base_q <= wr_base ? hwdata[15:0] : rom_rdata;
      end
      if (wr_gp || ld_gp) gp_q <= wr_gp ? hwdata[15:0] : rom_rdata;
      if (wr_ptr) ptr_q <= hwdata[15:0];
    end
  end
  for (gi = 0; gi < 3; gi++) begin : g_sta
    wire ld_this = ld_sta && sta_idx == 3'(gi);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) sta_q[gi] <= SECL_STA_RST;
      else if (wr_sta[gi]) sta_q[gi] <= hwdata[15:0];
      else if (ld_this) sta_q[gi] <= rom_rdata;
    end
  end
  // ****************************************************
  // read data
  // ****************************************************
  wire [15:0] ctrl_rd = control_word_q
    | (busy ? 16'h0006 : 16'h0000);
  wire [15:0] stat_rd = {11'h000, busy, rom_present_pin, board_strap_pins};
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    unique case (1'b1)
      ap_addr_q == SECL_CTRL_OFS: rd_mux = ctrl_rd;
      ap_addr_q == SECL_CFG_OFS: rd_mux = cfg_q;
      ap_addr_q == SECL_BASE_OFS: rd_mux = base_q;
      ap_addr_q == SECL_STA0_OFS: rd_mux = sta_q[0];
      ap_addr_q == SECL_STA1_OFS: rd_mux = sta_q[1];
      ap_addr_q == SECL_STA2_OFS: rd_mux = sta_q[2];
      ap_addr_q == SECL_GP_OFS: rd_mux = gp_q;
      ap_addr_q == SECL_PTR_OFS: rd_mux = ptr_q;
      ap_addr_q == SECL_STAT_OFS: rd_mux = stat_rd;
      default: rd_mux = 16'h0000;
    endcase
  end
  assign hrdata = ap_q ? {16'h0000, rd_mux} : 32'h0000_0000;
  assign hreadyout = !stall;
  assign hresp = 1'b0;
  // ****************************************************
  // serial port
  // ****************************************************
  secl_uwire #(
    .SK_HALF(SK_HALF)
  ) u_uwire (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(rom_start),
    .cmd(word_cmd),
    .addr(word_addr),
    .wdata(word_out),
    .done(rom_done),
    .rdata(rom_rdata),
    .rom_cs(rom_cs),
    .rom_sk(rom_sk),
    .rom_di(rom_di),
    .rom_do(rom_do)
  );
  // ****************************************************
  // checks
  // ****************************************************
  a_busy_bits_high: assert property (@(posedge hclk) disable iff (!hresetn)
    ap_q && !ap_wr_q && sel_ctrl && busy |-> hrdata[2:1] == 2'b11)
    else $error("request bits not high while busy");
  a_block_access: assert property (@(posedge hclk) disable iff (!hresetn)
    ap_q && !sel_ctrl && seq_q != SECL_Q_IDLE |-> !hreadyout)
    else $error("register access not held during transfer");
  a_no_rom_start: assert property (@(posedge hclk) disable iff (!hresetn)
    !rom_present_pin && seq_q == SECL_Q_IDLE |=> seq_q == SECL_Q_IDLE)
    else $error("transfer started without eeprom");
  a_strap7_skip: assert property (@(posedge hclk) disable iff (!hresetn)
    start_now && go_load && !go_gp && skip_setup |=> step_q == 3'h2)
    else $error("strap 7 load did not skip setup words");
  a_setup_addr: assert property (@(posedge hclk) disable iff (!hresetn)
    rom_start && !gp_mode_q && step_q < 3'h2 && !ewen_q
    |-> word_addr == {1'b0, board_strap_pins, 1'b0, step_q[0]})
    else $error("setup word address wrong");
  a_station_addr: assert property (@(posedge hclk) disable iff (!hresetn)
    rom_start && !gp_mode_q && step_q >= 3'h2
    |-> word_addr == 6'h1E + {3'b000, step_q})
    else $error("station address word wrong");
  a_gp_addr: assert property (@(posedge hclk) disable iff (!hresetn)
    rom_start && gp_mode_q && !ewen_q |-> word_addr == ptr_q[5:0])
    else $error("single word address not from pointer");
  a_ewen_first: assert property (@(posedge hclk) disable iff (!hresetn)
    rom_start && word_cmd == SECL_CMD_WR |-> prev_cmd_q == SECL_CMD_EN)
    else $error("write not preceded by write enable");
  a_boot_load: assert property (@(posedge hclk) disable iff (!hresetn)
    boot_q && rom_present_pin |=> seq_q == SECL_Q_ISSUE ##1 load_q)
    else $error("reset did not start a load");
  a_cfg_kept: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_q != SECL_Q_IDLE && step_q >= 3'h2 && load_q |=> $stable(cfg_q))
    else $error("setup word changed during station load");
  c_gp_load: cover property (@(posedge hclk) disable iff (!hresetn)
    word_done && gp_mode_q && load_q);
  c_setup_save: cover property (@(posedge hclk) disable iff (!hresetn)
    word_done && !gp_mode_q && !load_q && step_q == 3'h1);
  c_strap7_load: cover property (@(posedge hclk) disable iff (!hresetn)
    start_now && go_load && skip_setup);
  c_gp_save: cover property (@(posedge hclk) disable iff (!hresetn)
    word_done && gp_mode_q && !load_q);
  c_no_rom_req: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl && !rom_present_pin && hwdata[SECL_LOAD_BIT]);
  a_ctrl_no_wait: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ap_q && sel_ctrl |-> hreadyout)
    else $error("control access delayed");
  a_ptr_blocked: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ap_q && ap_wr_q && busy |=> $stable(ptr_q))
    else $error("pointer written during transfer");
  a_idle_bits_low: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ap_q && !ap_wr_q && sel_ctrl && !busy |-> hrdata[2:1] == 2'b00)
    else $error("request bits high while idle");
  a_ctrl_no_req: assert property (
    @(posedge hclk) disable iff (!hresetn)
    control_word_q[2:1] == 2'b00)
    else $error("request bits stored in control word");
  a_rom_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !rom_present_pin && seq_q == SECL_Q_IDLE |-> !rom_cs)
    else $error("eeprom selected while absent");
  a_idle_no_frame: assert property (
    @(posedge hclk) disable iff (!hresetn)
    seq_q == SECL_Q_IDLE |-> !rom_cs && !rom_sk)
    else $error("serial lines active while idle");
  a_save_cfg_word: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rom_start && !gp_mode_q && word_cmd == SECL_CMD_WR && step_q == 3'h0
    |-> word_out == cfg_q && word_addr == {1'b0, board_strap_pins, 2'b00})
    else $error("setup save word wrong");
  a_gp_save_word: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rom_start && gp_mode_q && word_cmd == SECL_CMD_WR
    |-> word_out == gp_q && word_addr == ptr_q[5:0])
    else $error("single word save wrong");
  a_sta0_loaded: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ld_sta && sta_idx == 3'h0 |=> sta_q[0] == $past(rom_rdata))
    else $error("station word 0 not loaded");
  a_sta2_loaded: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ld_sta && sta_idx == 3'h2 |=> sta_q[2] == $past(rom_rdata))
    else $error("station word 2 not loaded");
  a_gp_loaded: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ld_gp |=> gp_q == $past(rom_rdata))
    else $error("single word not loaded into gp");
  a_load_wins: assert property (
    @(posedge hclk) disable iff (!hresetn)
    start_now && req_load |=> load_q)
    else $error("load request not started as load");
  a_sel_taken: assert property (
    @(posedge hclk) disable iff (!hresetn)
    start_now && !boot_go && hwdata[SECL_SEL_BIT] |=> gp_mode_q)
    else $error("target select not applied");
  a_upper_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hrdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
endmodule
`default_nettype wire

/* File: tb/secl_rom_model.sv */
// behavioural three-wire serial eeprom, 64 words of 16 bits
`timescale 1ns/10ps
`default_nettype none
module secl_rom_model #(
  parameter int WR_NS = 300
) (
  input wire logic rom_cs,
  input wire logic rom_sk,
  input wire logic rom_di,
  output logic rom_do
);
  logic [15:0] mem [0:63];
  logic [24:0] sr = '0;
  logic [1:0] op = '0;
  logic [5:0] adr = '0;
  logic st = 1'b0;
  logic wen = 1'b0;
  logic busy = 1'b0;
  logic do_q = 1'b0;
  int cnt = 0;
  int frames = 0;
  int bad = 0;
  // ****************************************************
  // serial shifter
  // ****************************************************
  assign rom_do = do_q;
  always @(posedge rom_cs) begin
    cnt = 0;
    do_q <= ~busy; // ready shown while selected
  end
  always @(negedge busy) begin
    if (rom_cs) do_q <= 1'b1;
  end
  always @(posedge rom_sk) begin
    if (rom_cs) begin
      sr = {sr[23:0], rom_di};
      cnt = cnt + 1;
      if (cnt == 9) begin
        st = sr[8];
        op = sr[7:6];
        adr = sr[5:0]; // six-bit word address
      end
      if (cnt == 9 && op == 2'b10) do_q <= 1'b0;
      if (cnt >= 10 && cnt <= 25 && op == 2'b10) do_q <= mem[adr][25-cnt];
    end
  end
  // ****************************************************
  // frame end: enable, write, framing faults
  // ****************************************************
  always @(negedge rom_cs) begin
    do_q <= ~do_q;
    if (cnt > 0) begin
      frames++;
      if (!st || !((cnt == 9 && op == 2'b00 && adr[5:4] == 2'b11) ||
          (cnt == 25 && op != 2'b00))) bad++;
      if (cnt == 9 && op == 2'b00) wen = 1'b1;
      if (cnt == 25 && op == 2'b01) begin
        if (wen) mem[adr] = sr[15:0]; // whole word
        else bad++; // write without enable
        wen = 1'b0;
        busy = 1'b1;
        busy <= #(WR_NS) 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/secl_loader_bench.sv */
// self-checking bench for the eeprom configuration loader
`timescale 1ns/10ps
`default_nettype none
module secl_loader_bench;
  import secl_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic rom_present_pin, rom_cs, rom_sk, rom_di, rom_do;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize, board_strap_pins;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int f0;
  // ****************************************************
  // clock and instances
  // ****************************************************
  always #5 hclk = ~hclk;
  assign hready = hreadyout;
  secl_loader #(.SK_HALF(2)) secl_loader_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .board_strap_pins(board_strap_pins),
    .rom_present_pin(rom_present_pin), .rom_cs(rom_cs), .rom_sk(rom_sk),
    .rom_di(rom_di), .rom_do(rom_do));
  secl_rom_model secl_rom_model_i (.rom_cs(rom_cs), .rom_sk(rom_sk),
    .rom_di(rom_di), .rom_do(rom_do));
  // ****************************************************
  // tasks
  // ****************************************************
  function automatic logic [15:0] romv(input int i);
    romv = {4'hC, 2'h0, i[5:0], 4'h5};
  endfunction
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    haddr <= {24'h00, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsel <= 1'b1;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(a, 1'b1, {16'h0000, d});
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h00000000);
    chk(nm, e, rv);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic poll;
    int k;
    k = 0;
    bus(SECL_CTRL_OFS, 1'b0, 32'h00000000);
    while (rv[2:1] !== 2'b00 && k < 5000) begin
      bus(SECL_CTRL_OFS, 1'b0, 32'h00000000);
      k++;
    end
  endtask
  task automatic do_reset(input logic [2:0] s, input logic p);
    hresetn <= 1'b0;
    board_strap_pins <= s;
    rom_present_pin <= p;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  task automatic tdone(input string nm);
    $display("test %s done", nm);
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      $display("MISMATCH timeout expected 0 seen 1");
      end_sim;
    end
  end
  // ****************************************************
  // tests
  // ****************************************************
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    board_strap_pins = 3'h3;
    rom_present_pin = 1'b1;
    for (int i = 0; i < 64; i++) secl_rom_model_i.mem[i] = romv(i);
    do_reset(3'h3, 1'b1);
    rd("ctrl busy", SECL_CTRL_OFS, 32'h00000006);
    rd("cfg", SECL_CFG_OFS, {16'h0000, romv(12)});
    rd("base", SECL_BASE_OFS, {16'h0000, romv(13)});
    for (int i = 0; i < 3; i++) begin
      rd("station", SECL_STA0_OFS + 8'(4 * i), {16'h0000, romv(32 + i)});
    end
    rd("unmapped", 8'h40, 32'h00000000);
    tdone("reset load");
    wr(SECL_CFG_OFS, 16'h1234);
    wr(SECL_BASE_OFS, 16'h5678);
    board_strap_pins <= 3'h7;
    secl_rom_model_i.mem[33] = 16'h9ABC;
    wr(SECL_CTRL_OFS, 16'h00FA);
    rd("ctrl run", SECL_CTRL_OFS, 32'h000000FE);
    poll;
    chk("ctrl kept", 32'h000000F8, rv);
    rd("cfg kept", SECL_CFG_OFS, 32'h00001234);
    rd("base kept", SECL_BASE_OFS, 32'h00005678);
    rd("station1", SECL_STA1_OFS, 32'h00009ABC);
    tdone("reload fixed strap");
    f0 = secl_rom_model_i.frames;
    do_reset(3'h7, 1'b1);
    rd("cfg dflt", SECL_CFG_OFS, 32'h00000000);
    rd("base dflt", SECL_BASE_OFS, 32'h00000000);
    rd("station0", SECL_STA0_OFS, {16'h0000, romv(32)});
    rd("status strap", SECL_STAT_OFS, 32'h0000000F);
    chk("frames", 32'd3, 32'(secl_rom_model_i.frames - f0));
    tdone("reset fixed strap");
    wr(SECL_CFG_OFS, 16'h1357);
    wr(SECL_BASE_OFS, 16'h2468);
    board_strap_pins <= 3'h5;
    wr(SECL_CTRL_OFS, 16'h0004);
    poll;
    chk("rom ready", 32'h0, {31'h0, secl_rom_model_i.busy});
    chk("save cfg", 32'h1357, {16'h0, secl_rom_model_i.mem[20]});
    chk("save base", 32'h2468, {16'h0, secl_rom_model_i.mem[21]});
    tdone("save");
    wr(SECL_PTR_OFS, 16'hFFFF);
    wr(SECL_CTRL_OFS, 16'h0003);
    poll;
    rd("gp load", SECL_GP_OFS, {16'h0000, romv(63)});
    rd("cfg same", SECL_CFG_OFS, 32'h00001357);
    wr(SECL_GP_OFS, 16'hBEEF);
    wr(SECL_PTR_OFS, 16'h0041);
    wr(SECL_CTRL_OFS, 16'h0005);
    poll;
    chk("gp save", 32'hBEEF, {16'h0, secl_rom_model_i.mem[1]});
    chk("other word", 32'h1357, {16'h0, secl_rom_model_i.mem[20]});
    chk("bad frames", 32'h0, 32'(secl_rom_model_i.bad));
    tdone("single word");
    f0 = secl_rom_model_i.frames;
    do_reset(3'h3, 1'b0);
    rd("cfg none", SECL_CFG_OFS, 32'h00000000);
    rd("station2 none", SECL_STA2_OFS, 32'h00000000);
    rd("status none", SECL_STAT_OFS, 32'h00000003);
    wr(SECL_CTRL_OFS, 16'h0002);
    rd("ctrl none", SECL_CTRL_OFS, 32'h00000000);
    chk("no frames", 32'd0, 32'(secl_rom_model_i.frames - f0));
    tdone("no eeprom");
    end_sim;
  end
endmodule
`default_nettype wire
